/* core/gpio_regs.svh */
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define FIRST_PORT_DATA_IDX 8'h05
`define SECOND_PORT_DATA_IDX 8'h07
`define COMPARATOR_CONTROL_IDX 8'h1f
`define FIRST_PORT_DIRECTION_IDX 8'h85
`define SECOND_PORT_DIRECTION_IDX 8'h87
`define VOLTAGE_REFERENCE_CONTROL_IDX 8'h9f
`define PORT_VARIANT_IDX 8'hfe

// ************************************************************
// field positions
// ************************************************************
`define VREF_ENABLE_BIT 7
`define VREF_ON_PIN_BIT 6
`define WRITE_MASK_LSB 8
`define OPEN_DRAIN_BIT 4
`define VREF_PIN_BIT 2

// ************************************************************
// reset values
// ************************************************************
`define FIRST_DIRECTION_RESET 6'h3f
`define SECOND_DIRECTION_RESET 8'hff
`define SECOND_LATCH_RESET 8'h00
`define FIRST_LATCH_RESET 6'h00
`define VOLTAGE_REFERENCE_RESET 8'h00

`endif

/* core/gpio_pkg.sv */
package gpio_pkg;

  // comparator mode field of the comparator control register
  typedef enum logic [2:0] {
    CMP_MODE_RESET = 3'h0,
    CMP_MODE_OUTPUTS_ON_PINS = 3'h6,
    CMP_MODE_OFF = 3'h7
  } cmp_mode_t;

  // bus slave phase, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_t;

endpackage

/* core/pin_sync.sv */
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* core/port_pad.sv */
`timescale 1ns/100ps

module port_pad #(
  parameter int W = 8,
  parameter logic [W-1:0] OD_MASK = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] alt_en,
  input wire logic [W-1:0] alt_val,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);

  wire [W-1:0] drive_val = (alt_en & alt_val) | (~alt_en & latch);
  // open-drain bits only pull low; push-pull bits drive both levels
  wire [W-1:0] out_next = drive_val & ~OD_MASK;
  wire [W-1:0] oe_next = ~dir & (~OD_MASK | ~drive_val);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= out_next;
      pin_oe <= oe_next;
    end
  end

endmodule

/* core/gpio_port_a_and_c.sv */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "gpio_regs.svh"

// Notes on behaviour
// - first port is a six-bit latch with a direction bit per pin
// - first port bit 4 is open-drain pull-low and feeds the timer clock
// - other first-port pins drive push-pull
// - direction one floats the driver, zero drives the latch value
// - data read returns pin levels, data write loads the latch
// - writes are read-modify-write: pins read, bits merged, whole latch written
// - comparator and reference controls select digital or analog use
// - pins used as comparator inputs read as zero
// - reset sets first-port inputs, disables digital inputs on bits 0..3, grounds comparator inputs
// - direction bits keep driver control in analog use; software keeps inputs
// - bit 2 carries the reference output; software sets its direction input
// - one comparator mode drives results onto bits 3 and 4
// - only comparator outputs take over pin values (bits 3 and 4); every shared use leaves drivers to direction
// - second port is eight bidirectional pins, one direction bit each
// - second direction resets to all ones; latch resets to zero
// - variant has three or five ports
module gpio_port_a_and_c #(
  parameter int NUM_PORTS = 3,
  parameter int FIRST_W = 6,
  parameter int SECOND_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [5:0] first_port_in,
  output logic [5:0] first_port_out,
  output logic [5:0] first_port_oe,
  input wire logic [7:0] second_port_in,
  output logic [7:0] second_port_out,
  output logic [7:0] second_port_oe,
  input wire logic [1:0] comparator_result,
  output logic [3:0] comparator_input_ground,
  output logic vref_output_enable,
  output logic timer_external_clock_in
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (NUM_PORTS != 3 && NUM_PORTS != 5) begin : g_bad_variant
    $error("NUM_PORTS must be 3 or 5");
  end
  if (FIRST_W != 6 || SECOND_W != 8) begin : g_bad_width
    $error("port widths must be 6 and 8");
  end

  // ************************************************************
  // state
  // ************************************************************
  gpio_pkg::bus_state_t bus_state_reg;
  logic [7:0] idx_reg;
  logic wr_reg;
  logic [5:0] first_latch_reg;
  logic [5:0] first_dir_reg;
  logic [7:0] second_latch_reg;
  logic [7:0] second_dir_reg;
  logic [2:0] cmp_mode_reg;
  logic [7:0] vref_ctrl_reg;
  logic [5:0] first_sync;
  logic [7:0] second_sync;
  logic [1:0] cmp_sync;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  pin_sync #(.W(6)) u_first_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(first_port_in),
    .sync_out(first_sync)
  );

  pin_sync #(.W(10)) u_second_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in({comparator_result, second_port_in}),
    .sync_out({cmp_sync, second_sync})
  );

  // ************************************************************
  // pin function selection
  // ************************************************************
  wire cmp_off = (cmp_mode_reg == gpio_pkg::CMP_MODE_OFF);
  wire cmp_on_pins = (cmp_mode_reg == gpio_pkg::CMP_MODE_OUTPUTS_ON_PINS);
  wire cmp_in_reset = (cmp_mode_reg == gpio_pkg::CMP_MODE_RESET);
  wire vref_on_pin = vref_ctrl_reg[`VREF_ENABLE_BIT] & vref_ctrl_reg[`VREF_ON_PIN_BIT];
  // bits 0..3 are comparator inputs unless comparators are off; with results on pins bit 3 becomes an output
  wire [5:0] cmp_in_mask = cmp_off ? 6'h00 : (cmp_on_pins ? 6'h07 : 6'h0f);
  wire [5:0] vref_mask = vref_on_pin ? 6'h04 : 6'h00;
  wire [5:0] analog_mask = cmp_in_mask | vref_mask;
  wire [5:0] first_alt_en = cmp_on_pins ? 6'h18 : 6'h00;
  wire [5:0] first_alt_val = {1'b0, cmp_sync[1], cmp_sync[0], 3'h0};

  // ************************************************************
  // pads
  // ************************************************************
  port_pad #(.W(6), .OD_MASK(6'h10)) u_first_pad (
    .clk(hclk),
    .rst_n(hresetn),
    .latch(first_latch_reg),
    .dir(first_dir_reg),
    .alt_en(first_alt_en),
    .alt_val(first_alt_val),
    .pin_out(first_port_out),
    .pin_oe(first_port_oe)
  );

  port_pad #(.W(8), .OD_MASK(8'h00)) u_second_pad (
    .clk(hclk),
    .rst_n(hresetn),
    .latch(second_latch_reg),
    .dir(second_dir_reg),
    .alt_en(8'h00),
    .alt_val(8'h00),
    .pin_out(second_port_out),
    .pin_oe(second_port_oe)
  );

  // ************************************************************
  // bus decode
  // ************************************************************
  wire addr_take = hsel & hready & htrans[1] & (bus_state_reg == gpio_pkg::BUS_IDLE);
  wire addr_ok = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
  wire [7:0] addr_idx = addr_ok ? haddr[9:2] : 8'h00;
  wire data_phase = (bus_state_reg == gpio_pkg::BUS_DATA);
  wire do_write = data_phase & wr_reg;
  wire [5:0] first_read = first_sync & ~analog_mask;
  wire [7:0] second_read = second_sync;
  wire [7:0] wmask = (hwdata[15:8] == 8'h00) ? 8'hff : hwdata[15:8];
  // merge written bits over the sampled pin levels
  wire [5:0] first_latch_next = (first_read & ~wmask[5:0]) | (hwdata[5:0] & wmask[5:0]);
  wire [7:0] second_latch_next = (second_read & ~wmask) | (hwdata[7:0] & wmask);
  wire [7:0] variant_val = 8'(NUM_PORTS);
  wire [31:0] read_mux =
    (idx_reg == `FIRST_PORT_DATA_IDX) ? {26'h0, first_read} :
    (idx_reg == `SECOND_PORT_DATA_IDX) ? {24'h0, second_read} :
    (idx_reg == `FIRST_PORT_DIRECTION_IDX) ? {26'h0, first_dir_reg} :
    (idx_reg == `SECOND_PORT_DIRECTION_IDX) ? {24'h0, second_dir_reg} :
    (idx_reg == `COMPARATOR_CONTROL_IDX) ? {29'h0, cmp_mode_reg} :
    (idx_reg == `VOLTAGE_REFERENCE_CONTROL_IDX) ? {24'h0, vref_ctrl_reg} :
    (idx_reg == `PORT_VARIANT_IDX) ? {24'h0, variant_val} : 32'h0;

  // ************************************************************
  // bus slave, one wait state per transfer
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= gpio_pkg::BUS_IDLE;
      idx_reg <= 8'h00;
      wr_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else begin
      unique case (bus_state_reg)
        gpio_pkg::BUS_IDLE: begin
          if (addr_take) begin
            bus_state_reg <= gpio_pkg::BUS_DATA;
            idx_reg <= addr_ok ? addr_idx : 8'hff;
            wr_reg <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        gpio_pkg::BUS_DATA: begin
          bus_state_reg <= gpio_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata <= wr_reg ? 32'h0 : read_mux;
        end
        default: begin
          bus_state_reg <= gpio_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_latch_reg <= `FIRST_LATCH_RESET;
      first_dir_reg <= `FIRST_DIRECTION_RESET;
      second_latch_reg <= `SECOND_LATCH_RESET;
      second_dir_reg <= `SECOND_DIRECTION_RESET;
      cmp_mode_reg <= gpio_pkg::CMP_MODE_RESET;
      vref_ctrl_reg <= `VOLTAGE_REFERENCE_RESET;
    end else if (do_write) begin
      if (idx_reg == `FIRST_PORT_DATA_IDX) begin
        first_latch_reg <= first_latch_next;
      end
      if (idx_reg == `SECOND_PORT_DATA_IDX) begin
        second_latch_reg <= second_latch_next;
      end
      if (idx_reg == `FIRST_PORT_DIRECTION_IDX) begin
        first_dir_reg <= hwdata[5:0];
      end
      if (idx_reg == `SECOND_PORT_DIRECTION_IDX) begin
        second_dir_reg <= hwdata[7:0];
      end
      if (idx_reg == `COMPARATOR_CONTROL_IDX) begin
        cmp_mode_reg <= hwdata[2:0];
      end
      if (idx_reg == `VOLTAGE_REFERENCE_CONTROL_IDX) begin
        vref_ctrl_reg <= hwdata[7:0];
      end
    end
  end

  // ************************************************************
  // peripheral side outputs
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_input_ground <= 4'hf;
      vref_output_enable <= 1'b0;
      timer_external_clock_in <= 1'b0;
    end else begin
      comparator_input_ground <= cmp_in_reset ? 4'hf : 4'h0;
      vref_output_enable <= vref_on_pin;
      timer_external_clock_in <= first_sync[`OPEN_DRAIN_BIT];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence addr_phase_s;
    addr_take;
  endsequence

  sequence wait_then_ready_s;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_bus_timing;
    @(posedge hclk) disable iff (!hresetn) addr_phase_s |=> wait_then_ready_s;
  endproperty

  AST_BUS_ONE_WAIT: assert property (p_bus_timing) else $error("bus answer not after one wait");

  AST_OPEN_DRAIN: assert property (
    @(posedge hclk) disable iff (!hresetn)
      !first_port_out[4] && (!first_port_oe[4] || $past(!first_latch_reg[4] || cmp_on_pins))
  ) else $error("bit 4 drove high");

  AST_DIR_FLOATS: assert property (
    @(posedge hclk) disable iff (!hresetn) first_dir_reg[0] |=> !first_port_oe[0]
  ) else $error("first port bit 0 driven while input");

  AST_DIR_DRIVES: assert property (
    @(posedge hclk) disable iff (!hresetn)
      !second_dir_reg[7]
      |=> second_port_oe[7] && second_port_out[7] == $past(second_latch_reg[7])
  ) else $error("second port bit 7 not driving latch");

  AST_ANALOG_READS_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
      (data_phase && !wr_reg && idx_reg == `FIRST_PORT_DATA_IDX && !cmp_off)
      |=> hrdata[0] == 1'b0
  ) else $error("comparator input did not read zero");

  AST_WRITE_LATCH: assert property (
    @(posedge hclk) disable iff (!hresetn)
      (do_write && idx_reg == `SECOND_PORT_DATA_IDX && hwdata[15:8] == 8'h00)
      |=> second_latch_reg == $past(hwdata[7:0])
  ) else $error("second latch not loaded");

  AST_UPPER_DIR_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
      (data_phase && !wr_reg && idx_reg == `FIRST_PORT_DIRECTION_IDX)
      |=> hrdata[31:6] == 26'h0
  ) else $error("upper direction bits not zero");

  AST_GROUND_IN_RESET_MODE: assert property (
    @(posedge hclk) disable iff (!hresetn) cmp_in_reset |=> comparator_input_ground == 4'hf
  ) else $error("comparator inputs not grounded");

  AST_CMP_ROUTE: assert property (
    @(posedge hclk) disable iff (!hresetn)
      (cmp_on_pins && !first_dir_reg[3]) |=> first_port_out[3] == $past(cmp_sync[0])
  ) else $error("comparator result not on bit 3");

  AST_SECOND_READ_PINS: assert property (
    @(posedge hclk) disable iff (!hresetn)
      (data_phase && !wr_reg && idx_reg == `SECOND_PORT_DATA_IDX)
      |=> hrdata == {24'h0, $past(second_sync)}
  ) else $error("second port read not pin levels");

  AST_TIMER_FOLLOWS_PIN: assert property (
    @(posedge hclk) disable iff (!hresetn)
      timer_external_clock_in == $past(first_sync[`OPEN_DRAIN_BIT])
  ) else $error("timer clock does not follow bit 4");

  AST_RESP_OKAY: assert property (
    @(posedge hclk) disable iff (!hresetn) hresp == 1'b0 && $stable(hresp)
  ) else $error("response not okay");

endmodule

/* tb/pin_partner.sv */
`timescale 1ns/100ps

// ************************************************************
// external circuitry on both ports
// ************************************************************
module pin_partner (
  input wire logic [5:0] a_out,
  input wire logic [5:0] a_oe,
  input wire logic [5:0] ext_a,
  output logic [5:0] a_pin,
  input wire logic [7:0] c_out,
  input wire logic [7:0] c_oe,
  input wire logic [7:0] ext_c,
  output logic [7:0] c_pin
);
  // a driven pin shows the device value, a released one the outside level
  // bit 4 only ever drives low, so outside it acts as a pulled line
  assign a_pin = (a_oe & a_out) | (~a_oe & ext_a);
  assign c_pin = (c_oe & c_out) | (~c_oe & ext_c);
endmodule

/* tb/gpio_port_a_and_c_test.sv */
`timescale 1ns/100ps
`include "gpio_regs.svh"

module gpio_port_a_and_c_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] comparator_result = 2'h0;
  logic [5:0] ext_a = 6'h2a;
  logic [7:0] ext_c = 8'h00;
  logic [31:0] rd;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [5:0] a_pin;
  wire [5:0] a_out;
  wire [5:0] a_oe;
  wire [7:0] c_pin;
  wire [7:0] c_out;
  wire [7:0] c_oe;
  wire [3:0] cmp_gnd;
  wire vref_en;
  wire tmr_clk;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  always #50 hclk = ~hclk;

  gpio_port_a_and_c i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .first_port_in(a_pin), .first_port_out(a_out), .first_port_oe(a_oe),
    .second_port_in(c_pin), .second_port_out(c_out), .second_port_oe(c_oe),
    .comparator_result(comparator_result), .comparator_input_ground(cmp_gnd),
    .vref_output_enable(vref_en), .timer_external_clock_in(tmr_clk)
  );

  pin_partner i_partner (
    .a_out(a_out), .a_oe(a_oe), .ext_a(ext_a), .a_pin(a_pin),
    .c_out(c_out), .c_oe(c_oe), .ext_c(ext_c), .c_pin(c_pin)
  );

  // ************************************************************
  // bus master and checking
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 32'h0);
  endtask

  // lets pad flops and the two-flop pin synchronisers catch up
  task automatic settle;
    repeat (4) @(posedge hclk);
    #1;
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    check({cmp_gnd, a_oe, c_oe}, {14'h0, 4'hf, 14'h0});
    bus(1'b0, `FIRST_PORT_DIRECTION_IDX, 32'h0);
    check(rd, 32'h3f);
    bus(1'b0, `SECOND_PORT_DIRECTION_IDX, 32'h0);
    check(rd, 32'hff);
    bus(1'b0, `PORT_VARIANT_IDX, 32'h0);
    check(rd, 32'h3);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `FIRST_PORT_DATA_IDX, 32'h0);
    check(rd, 32'h20);
  endtask

  task automatic t_second;
    @(posedge hclk);
    ext_c <= 8'h3c;
    bus(1'b1, `SECOND_PORT_DATA_IDX, 32'ha5);
    bus(1'b1, `SECOND_PORT_DIRECTION_IDX, 32'h0f);
    settle();
    check(c_oe, 8'hf0);
    check(c_out & c_oe, 8'ha0);
    bus(1'b0, `SECOND_PORT_DATA_IDX, 32'h0);
    check(rd, 32'hac);
    // clears only bit 7, the rest of the latch takes the pin levels
    bus(1'b1, `SECOND_PORT_DATA_IDX, 32'h8000);
    bus(1'b1, `SECOND_PORT_DIRECTION_IDX, 32'h0);
    settle();
    check(c_out, 8'h2c);
  endtask

  task automatic t_first;
    @(posedge hclk);
    ext_a <= 6'h10;
    bus(1'b1, `COMPARATOR_CONTROL_IDX, 32'h7);
    bus(1'b1, `FIRST_PORT_DATA_IDX, 32'h3f);
    bus(1'b1, `FIRST_PORT_DIRECTION_IDX, 32'h0);
    settle();
    check(cmp_gnd, 4'h0);
    check(a_oe, 6'h2f);
    check(a_out & 6'h2f, 6'h2f);
    check(tmr_clk, 1'b1);
    bus(1'b1, `FIRST_PORT_DATA_IDX, 32'h0);
    settle();
    check({a_oe, a_out}, 12'hfc0);
    check(tmr_clk, 1'b0);
    bus(1'b1, `FIRST_PORT_DIRECTION_IDX, 32'h3f);
    @(posedge hclk);
    ext_a <= 6'h15;
    settle();
    check(a_oe, 6'h0);
    bus(1'b0, `FIRST_PORT_DATA_IDX, 32'h0);
    check(rd, 32'h15);
  endtask

  task automatic t_analog;
    // comparator pins stay inputs, bits 4:3 cleared to carry the results
    bus(1'b1, `FIRST_PORT_DIRECTION_IDX, 32'h27);
    bus(1'b1, `COMPARATOR_CONTROL_IDX, 32'h6);
    @(posedge hclk);
    comparator_result <= 2'b01;
    settle();
    check({a_oe[4:3], a_out[3]}, 3'b111);
    @(posedge hclk);
    comparator_result <= 2'b10;
    settle();
    check({a_oe[4:3], a_out[3]}, 3'b010);
    bus(1'b0, `FIRST_PORT_DATA_IDX, 32'h0);
    check(rd, 32'h10);
    bus(1'b1, `FIRST_PORT_DIRECTION_IDX, 32'h3f);
    settle();
    check(a_oe, 6'h0);
    // a plain comparator mode: bits 0..3 analog, inputs no longer grounded
    bus(1'b1, `COMPARATOR_CONTROL_IDX, 32'h2);
    settle();
    check(cmp_gnd, 4'h0);
    bus(1'b0, `FIRST_PORT_DATA_IDX, 32'h0);
    check(rd, 32'h10);
    bus(1'b1, `COMPARATOR_CONTROL_IDX, 32'h7);
    bus(1'b1, `VOLTAGE_REFERENCE_CONTROL_IDX, 32'hc0);
    settle();
    check(vref_en, 1'b1);
    bus(1'b0, `FIRST_PORT_DATA_IDX, 32'h0);
    check(rd, 32'h11);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_second();
    t_first();
    t_analog();
    results();
  end
endmodule
